// ---- shared/hpit_pkg.sv ----
package hpit_pkg;

   localparam int ADDR_W  = 7;
   localparam int DATA_W  = 16;
   localparam int BYTE_W  = 8;

   // Host-writable words sit at the bottom of the map
   localparam int           WREGS          = 6;
   localparam logic [6:0]   ADR_CTRL0      = 7'h00;
   localparam logic [6:0]   ADR_CTRL_CLR   = 7'h02;
   localparam logic [6:0]   ADR_STAT_EN    = 7'h04;
   localparam logic [6:0]   ADR_LINK_EN    = 7'h05;
   localparam logic [6:0]   ADR_STAT_STS   = 7'h10;
   localparam logic [6:0]   ADR_LINK_STS   = 7'h11;
   localparam logic [6:0]   ADR_LINE_SNAP  = 7'h12;
   localparam logic [6:0]   ADR_RX_CNT     = 7'h13;

   localparam int           CTRL_CLR_BIT   = 9;
   localparam logic [15:0]  WREG_RST       = 16'h0000;
   localparam logic [15:0]  UNMAPPED_RD    = 16'h0000;

   // Status sources
   localparam int           STAT_EXT_N     = 8;
   localparam int           STAT_N         = 10;
   localparam int           STAT_OVF_BIT   = 8;
   localparam int           STAT_SEC_BIT   = 9;
   localparam int           LINK_N         = 2;
   localparam logic [7:0]   RX_SIDE_MASK   = 8'h0F;

   // Timing
   localparam int           CLK_NS         = 50;
   localparam int           RESET_MIN_NS   = 100;
   localparam int           RESET_MIN_CYC  = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int           REF_PER_SEC    = 8000;
   localparam int           SEC_CNT_W      = 13;

   typedef enum logic {HPIT_ST_IDLE, HPIT_ST_ACC} hpit_state_t;

   typedef struct packed {
      logic              write;
      logic              lane_hi;
      logic [ADDR_W-1:0] addr;
   } hpit_acc_t;

   typedef struct packed {
      logic [STAT_EXT_N-1:0] stat;
      logic                  hdlc;
      logic                  far_end_alarm_chan;
   } hpit_evt_t;

endpackage

// ---- hdl/hpit_irq.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpit_irq
   import hpit_pkg::*;
#(
   parameter int N = 8
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         ce_in,
   // Sources
   input  wire logic [N-1:0] event_in,
   input  wire logic [N-1:0] enable_in,
   input  wire logic [N-1:0] clear_in,
   // Results
   output logic      [N-1:0] status_out,
   output logic              irq_n_out,
   output logic              irq_oe_n_out
);

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         // An event in the clearing cycle survives the clear
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               status_out[g] <= 1'b0;
            end else if (ce_in) begin
               status_out[g] <= event_in[g] | (status_out[g] & ~clear_in[g]);
            end
         end
      end
   endgenerate

   // Open drain: level is always low, only the enable moves
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_n_out    <= 1'b0;
         irq_oe_n_out <= 1'b1;
      end else if (ce_in) begin
         irq_n_out    <= 1'b0;
         irq_oe_n_out <= ~|(status_out & enable_in);
      end
   end

endmodule
`default_nettype wire

// ---- hdl/hpit_one_sec.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpit_one_sec
   import hpit_pkg::*;
#(
   parameter int PER_SEC = REF_PER_SEC
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   input  wire logic sm_rst_in,
   // Reference
   input  wire logic ref_8khz_in,
   // Results
   output logic      tick_8k_out,
   output logic      sec_pulse_out
);

   logic                 ref_prev;
   logic [SEC_CNT_W-1:0] count;
   wire                  ref_rise = ref_8khz_in & ~ref_prev;
   wire                  wrap     = (count == SEC_CNT_W'(PER_SEC - 1));

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_prev      <= 1'b0;
         count         <= '0;
         tick_8k_out   <= 1'b0;
         sec_pulse_out <= 1'b0;
      end else if (ce_in) begin
         ref_prev      <= ref_8khz_in;
         tick_8k_out   <= ref_rise & ~sm_rst_in;
         sec_pulse_out <= ref_rise & wrap & ~sm_rst_in;
         if (sm_rst_in) begin
            count <= '0;
         end else if (ref_rise) begin
            count <= wrap ? '0 : count + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ---- hdl/hpit_host_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpit_host_port
   import hpit_pkg::*;
#(
   parameter int PER_SEC = REF_PER_SEC
) (
   // Clock, reset, enable
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   ce_in,
   input  wire logic                   reset_in,
   // Host bus
   input  wire logic                   cs_n_in,
   input  wire logic                   addr_strobe_n_in,
   input  wire logic                   write_in,
   input  wire logic                   oe_n_in,
   input  wire logic [ADDR_W-1:0]      addr_in,
   input  wire logic                   bus_width_select_in,
   input  wire logic [DATA_W-1:0]      data_in,
   output logic      [DATA_W-1:0]      data_out,
   output logic      [1:0]             data_oe_n_out,
   // Interrupt pins
   output logic                        stat_irq_n_out,
   output logic                        stat_irq_oe_n_out,
   output logic                        link_irq_n_out,
   output logic                        link_irq_oe_n_out,
   // Timing
   input  wire logic                   ref_8khz_in,
   input  wire logic                   sec_sync_in,
   output logic                        sec_pulse_out,
   output logic                        frame_sync_out,
   // Receiver
   input  wire logic                   rx_hold_in,
   input  wire logic                   rx_clk_active_in,
   input  wire logic                   rx_cell_in,
   output logic                        rx_accept_out,
   // Events and line state
   input  wire hpit_evt_t              evt_in,
   input  wire logic [DATA_W-1:0]      line_status_in,
   // Control words to the rest of the device
   output logic [WREGS-1:0][DATA_W-1:0] ctrl_out
);

   hpit_state_t          state;
   hpit_state_t          next_state;
   hpit_acc_t            acc;
   logic [DATA_W-1:0]    wregs [WREGS];
   logic [DATA_W-1:0]    rd_shown;
   logic [BYTE_W-1:0]    hi_latch;
   logic [DATA_W-1:0]    line_snap;
   logic [DATA_W-1:0]    rx_cnt;
   logic                 sync_prev;
   logic [1:0]           rst_cnt;
   logic [STAT_N-1:0]    stat_sts;
   logic [LINK_N-1:0]    link_sts;
   logic                 sec_tick;
   logic [STAT_N-1:0]    stat_clr;
   logic [LINK_N-1:0]    link_clr;

   // Reset pin must be seen for the minimum width before it acts,
   // which also keeps a single-cycle glitch from wiping the machines.
   wire sm_rst = reset_in & (rst_cnt == 2'(RESET_MIN_CYC - 1));

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_cnt <= '0;
      end else if (ce_in) begin
         if (!reset_in) begin
            rst_cnt <= '0;
         end else if (!sm_rst) begin
            rst_cnt <= rst_cnt + 1'b1;
         end
      end
   end

   // Access sequencing
   wire start    = ~addr_strobe_n_in & ~cs_n_in & ~sm_rst;
   wire exec     = (state == HPIT_ST_ACC) & addr_strobe_n_in & ~cs_n_in & ~sm_rst;
   wire wr_fire  = exec & acc.write;
   wire rd_fire  = exec & ~acc.write;
   wire byte_md  = bus_width_select_in;

   always_comb begin
      next_state = state;
      case (state)
         HPIT_ST_IDLE: begin
            if (start) begin
               next_state = HPIT_ST_ACC;
            end
         end
         HPIT_ST_ACC: begin
            if (start) begin
               next_state = HPIT_ST_ACC;
            end else if (exec || cs_n_in || sm_rst) begin
               next_state = HPIT_ST_IDLE;
            end
         end
         default: begin
            next_state = HPIT_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= HPIT_ST_IDLE;
      end else if (ce_in) begin
         state <= sm_rst ? HPIT_ST_IDLE : next_state;
      end
   end

   // Address, direction and lane are taken on the strobe edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc <= '0;
      end else if (ce_in && !addr_strobe_n_in) begin
         acc.addr    <= addr_in;
         acc.write   <= write_in;
         acc.lane_hi <= data_in[DATA_W-1];
      end
   end

   // Read decode of the address being loaded
   wire rd_is_w    = addr_in < ADDR_W'(WREGS);
   wire [DATA_W-1:0] rd_word =
      rd_is_w                     ? wregs[addr_in[2:0]] :
      (addr_in == ADR_STAT_STS)   ? DATA_W'(stat_sts) :
      (addr_in == ADR_LINK_STS)   ? DATA_W'(link_sts) :
      (addr_in == ADR_LINE_SNAP)  ? line_snap :
      (addr_in == ADR_RX_CNT)     ? rx_cnt :
                                    UNMAPPED_RD;
   wire rd_lane_hi = data_in[DATA_W-1];
   wire [DATA_W-1:0] rd_drive =
      !byte_md   ? rd_word :
      rd_lane_hi ? {{BYTE_W{1'b0}}, hi_latch} :
                   {{BYTE_W{1'b0}}, rd_word[BYTE_W-1:0]};

   // Read data stands for the cycle after the strobe edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_out      <= '0;
         data_oe_n_out <= 2'b11;
         rd_shown      <= '0;
      end else if (ce_in) begin
         if (start && !write_in) begin
            data_out      <= rd_drive;
            rd_shown      <= rd_word;
            data_oe_n_out <= oe_n_in ? 2'b11 : (byte_md ? 2'b10 : 2'b00);
         end else begin
            data_oe_n_out <= 2'b11;
         end
      end
   end

   // A low-lane or full-width read keeps the upper byte for later.
   // Reading the high lane first therefore returns stale data.
   wire rd_full = rd_fire & (~byte_md | ~acc.lane_hi);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hi_latch <= '0;
      end else if (ce_in && rd_full) begin
         hi_latch <= rd_shown[DATA_W-1:BYTE_W];
      end
   end

   // Status clears only the bits the host actually saw
   assign stat_clr = (rd_full && acc.addr == ADR_STAT_STS) ? rd_shown[STAT_N-1:0] : '0;
   assign link_clr = (rd_full && acc.addr == ADR_LINK_STS) ? rd_shown[LINK_N-1:0] : '0;

   // Write data merge for the addressed word
   wire [DATA_W-1:0] wr_cur  = wregs[acc.addr[2:0]];
   wire [DATA_W-1:0] wr_word =
      !byte_md          ? data_in :
      data_in[DATA_W-1] ? {data_in[BYTE_W-1:0], wr_cur[BYTE_W-1:0]} :
                          {wr_cur[DATA_W-1:BYTE_W], data_in[BYTE_W-1:0]};

   genvar g;
   generate
      for (g = 0; g < WREGS; g++) begin : g_wreg
         wire hit = wr_fire & (acc.addr == ADDR_W'(g));
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               wregs[g] <= WREG_RST;
            end else if (ce_in) begin
               if (hit) begin
                  wregs[g] <= wr_word;
               end else if (sm_rst && ADDR_W'(g) == ADR_CTRL_CLR) begin
                  wregs[g][CTRL_CLR_BIT] <= 1'b0;
               end
            end
         end
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               ctrl_out[g] <= WREG_RST;
            end else if (ce_in) begin
               ctrl_out[g] <= wregs[g];
            end
         end
      end
   endgenerate

   // Line status snapshot once a second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_prev <= 1'b0;
         line_snap <= '0;
      end else if (ce_in) begin
         sync_prev <= sec_sync_in;
         if (sec_sync_in && !sync_prev) begin
            line_snap <= line_status_in;
         end
      end
   end

   // Cell receiver: counting holds while the hold input is high
   wire cell_ok = rx_cell_in & ~rx_hold_in & rx_clk_active_in & ~sm_rst;
   wire rx_ovf  = cell_ok & (&rx_cnt);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_cnt        <= '0;
         rx_accept_out <= 1'b0;
      end else if (ce_in) begin
         rx_accept_out <= ~rx_hold_in & ~sm_rst;
         if (cell_ok) begin
            rx_cnt <= rx_cnt + 1'b1;
         end
      end
   end

   // Receive-side sources need a running receive clock
   wire [STAT_EXT_N-1:0] ext_ok = evt_in.stat & ~(RX_SIDE_MASK & {STAT_EXT_N{~rx_clk_active_in}});
   wire [STAT_N-1:0]     stat_ev = {sec_tick, rx_ovf, ext_ok};
   wire [LINK_N-1:0]     link_ev = {evt_in.hdlc, evt_in.far_end_alarm_chan};

   hpit_irq #(
      .N (STAT_N)
   ) u_stat_irq (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ce_in        (ce_in),
      .event_in     (stat_ev),
      .enable_in    (wregs[ADR_STAT_EN[2:0]][STAT_N-1:0]),
      .clear_in     (stat_clr),
      .status_out   (stat_sts),
      .irq_n_out    (stat_irq_n_out),
      .irq_oe_n_out (stat_irq_oe_n_out)
   );

   hpit_irq #(
      .N (LINK_N)
   ) u_link_irq (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ce_in        (ce_in),
      .event_in     (link_ev),
      .enable_in    (wregs[ADR_LINK_EN[2:0]][LINK_N-1:0]),
      .clear_in     (link_clr),
      .status_out   (link_sts),
      .irq_n_out    (link_irq_n_out),
      .irq_oe_n_out (link_irq_oe_n_out)
   );

   // The second pulse doubles as a status source
   hpit_one_sec #(
      .PER_SEC (PER_SEC)
   ) u_one_sec (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .ce_in         (ce_in),
      .sm_rst_in     (sm_rst),
      .ref_8khz_in   (ref_8khz_in),
      .tick_8k_out   (frame_sync_out),
      .sec_pulse_out (sec_tick)
   );

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sec_pulse_out <= 1'b0;
      end else if (ce_in) begin
         sec_pulse_out <= sec_tick;
      end
   end

endmodule
`default_nettype wire

// ---- testbench/hpit_host_port_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpit_host_port_props
   import hpit_pkg::*;
#(
   parameter int PER_SEC = REF_PER_SEC
) (
   // Clock and reset
   input wire logic                          clk_in,
   input wire logic                          rst_n_in,
   input wire logic                          ce_in,
   input wire logic                          reset_in,
   // Host bus
   input wire logic                          cs_n_in,
   input wire logic                          addr_strobe_n_in,
   input wire logic                          write_in,
   input wire logic                          oe_n_in,
   input wire logic [ADDR_W-1:0]             addr_in,
   input wire logic                          bus_width_select_in,
   input wire logic [1:0]                    data_oe_n_out,
   // Interrupts, timing, receiver
   input wire logic                          stat_irq_oe_n_out,
   input wire logic                          link_irq_oe_n_out,
   input wire logic                          sec_pulse_out,
   input wire logic                          frame_sync_out,
   input wire logic                          rx_hold_in,
   input wire logic                          rx_accept_out,
   input wire hpit_evt_t                     evt_in,
   input wire logic [WREGS-1:0][DATA_W-1:0]  ctrl_out
);
   logic        wr_q;
   logic [15:0] fcnt;
   wire         rd_any = ce_in && !cs_n_in && !addr_strobe_n_in && !write_in && !oe_n_in;
   wire         rd_go  = rd_any && !reset_in;
   wire         wr_ok  = wr_q && ce_in && !cs_n_in && addr_strobe_n_in;
   // Bits 3:0 left out: the receive side may be suppressed
   wire         st_hit = |(evt_in.stat[7:4] & ctrl_out[4][7:4]) && !reset_in;
   wire         lk_hit = |({evt_in.hdlc, evt_in.far_end_alarm_chan} & ctrl_out[5][1:0]) && !reset_in;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_q <= 1'b0;
         fcnt <= 16'h0000;
      end else if (ce_in) begin
         wr_q <= !cs_n_in && !addr_strobe_n_in && write_in && addr_in < 7'(WREGS);
         fcnt <= (sec_pulse_out || reset_in) ? 16'h0000 : fcnt + 16'(frame_sync_out);
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_read_window;
      data_oe_n_out == {$past(bus_width_select_in), 1'b0} ##1 data_oe_n_out == 2'b11;
   endsequence

   a_read_drive_lanes: assert property (rd_go |=> s_read_window)
      else $error("read did not drive the expected lanes for one cycle");
   a_oe_only_reads: assert property (data_oe_n_out != 2'b11 |-> $past(rd_any))
      else $error("data bus driven outside a read");
   // The copy trails the word by one edge, so the cause sits two edges back
   a_write_decoded: assert property (!$stable(ctrl_out) |-> $past(wr_ok, 2) || $past(reset_in, 2))
      else $error("control word changed without a mapped write");
   a_second_count: assert property (sec_pulse_out |-> $past(frame_sync_out) && fcnt == 16'(PER_SEC))
      else $error("second pulse not on the counted reference edge");
   a_stat_irq_low: assert property (st_hit && $stable(ctrl_out[4]) |-> ##2 !stat_irq_oe_n_out)
      else $error("enabled status event did not pull the status line");
   a_link_irq_low: assert property (lk_hit && $stable(ctrl_out[5]) |-> ##2 !link_irq_oe_n_out)
      else $error("enabled link event did not pull the link line");
   a_rx_hold_stop: assert property (rx_hold_in |=> !rx_accept_out)
      else $error("receiver accepting while held");
   a_reset_pin_idle: assert property (reset_in && $past(reset_in) |=> !rx_accept_out)
      else $error("reset pin did not idle the receiver");
endmodule
bind hpit_host_port hpit_host_port_props #(.PER_SEC(PER_SEC)) u_props (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reset_in(reset_in), .cs_n_in(cs_n_in),
   .addr_strobe_n_in(addr_strobe_n_in), .write_in(write_in), .oe_n_in(oe_n_in), .addr_in(addr_in),
   .bus_width_select_in(bus_width_select_in), .data_oe_n_out(data_oe_n_out),
   .stat_irq_oe_n_out(stat_irq_oe_n_out), .link_irq_oe_n_out(link_irq_oe_n_out),
   .sec_pulse_out(sec_pulse_out), .frame_sync_out(frame_sync_out), .rx_hold_in(rx_hold_in),
   .rx_accept_out(rx_accept_out), .evt_in(evt_in), .ctrl_out(ctrl_out)
);
`default_nettype wire

// ---- testbench/hpit_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpit_host_model (
   // Clock
   input  wire logic        clk_in,
   // Bus towards the port
   output logic             cs_n_out,
   output logic             addr_strobe_n_out,
   output logic             write_out,
   output logic             oe_n_out,
   output logic [6:0]       addr_out,
   output logic [15:0]      bus_out,
   // Read data
   input  wire logic [15:0] bus_in
);
   initial begin
      cs_n_out = 1'b1;
      addr_strobe_n_out = 1'b1;
      write_out = 1'b0;
      oe_n_out = 1'b1;
      addr_out = 7'h00;
      bus_out = 16'h0000;
   end

   // Strobe cycle, then execute cycle, as on a clocked RAM
   task automatic acc(input logic wr, input logic lane, input logic [6:0] a,
                      input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_in);
      #5;
      addr_strobe_n_out = 1'b0;
      cs_n_out = 1'b0;
      write_out = wr;
      oe_n_out = wr;
      addr_out = a;
      bus_out[15] = lane;
      @(posedge clk_in);
      #5;
      addr_strobe_n_out = 1'b1;
      if (wr) begin
         bus_out = d;
      end
      @(posedge clk_in);
      q = bus_in;
      #5;
      cs_n_out = 1'b1; // select held low with strobe high for the execute cycle only
      oe_n_out = 1'b1;
      // Released lines flip so a stale value cannot pass for a driven one
      addr_out = ~addr_out;
      bus_out = ~bus_out;
   endtask
endmodule
`default_nettype wire

// ---- testbench/hpit_host_port_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module hpit_host_port_bench
   import hpit_pkg::*;
;
   localparam int PER_SEC = 4;
   int                           fails;
   int                           checks_done;
   logic                         clk_in, rst_n_in, reset_in, bw, ref_8k, sec_sync;
   logic                         rx_hold, rx_clk_act, rx_cell, cs_n, as_n, wr, oe_n;
   logic                         sec_p, fsync, rx_acc, sirq, sirq_oe, lirq, lirq_oe;
   logic [1:0]                   doe_n;
   logic [6:0]                   addr;
   logic [15:0]                  din, dout, line_st, rd;
   hpit_evt_t                    evt;
   logic [WREGS-1:0][DATA_W-1:0] ctrl;

   hpit_host_model host (
      .clk_in(clk_in), .cs_n_out(cs_n), .addr_strobe_n_out(as_n), .write_out(wr),
      .oe_n_out(oe_n), .addr_out(addr), .bus_out(din), .bus_in(dout)
   );
   hpit_host_port #(.PER_SEC(PER_SEC)) DUT (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .reset_in(reset_in),
      .cs_n_in(cs_n), .addr_strobe_n_in(as_n), .write_in(wr), .oe_n_in(oe_n), .addr_in(addr),
      .bus_width_select_in(bw), .data_in(din), .data_out(dout), .data_oe_n_out(doe_n),
      .stat_irq_n_out(sirq), .stat_irq_oe_n_out(sirq_oe), .link_irq_n_out(lirq),
      .link_irq_oe_n_out(lirq_oe), .ref_8khz_in(ref_8k), .sec_sync_in(sec_sync),
      .sec_pulse_out(sec_p), .frame_sync_out(fsync), .rx_hold_in(rx_hold),
      .rx_clk_active_in(rx_clk_act), .rx_cell_in(rx_cell), .rx_accept_out(rx_acc),
      .evt_in(evt), .line_status_in(line_st), .ctrl_out(ctrl)
   );

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Offset so reference edges never land on the sampling edge
   initial begin
      ref_8k = 1'b0;
      #30;
      forever #62500 ref_8k = ~ref_8k;
   end

   task automatic close_out;
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic step;
      @(posedge clk_in);
      #5;
   endtask

   task automatic pulse_evt(input hpit_evt_t e);
      step;
      evt = e;
      step;
      evt = '0;
   endtask

   task automatic t_reset_vals;
      `CHK("data_oe_n", 2'b11, doe_n)
      `CHK("irq_pins", 4'b0101, {sirq, sirq_oe, lirq, lirq_oe})
      `CHK("ctrl_rst", '0, ctrl)
   endtask

   task automatic t_words;
      for (int i = 0; i < WREGS; i++) host.acc(1'b1, 1'b0, 7'(i), 16'(16'h1111 * (i + 1)), rd);
      host.acc(1'b1, 1'b0, 7'h06, 16'hFFFF, rd);
      host.acc(1'b1, 1'b0, ADR_LINE_SNAP, 16'hFFFF, rd);
      for (int i = 0; i < WREGS; i++) begin
         host.acc(1'b0, 1'b0, 7'(i), 16'h0000, rd);
         `CHK("word_rd", 16'(16'h1111 * (i + 1)), rd)
         `CHK("ctrl_word", 16'(16'h1111 * (i + 1)), ctrl[i])
      end
      host.acc(1'b0, 1'b0, ADR_LINE_SNAP, 16'h0000, rd);
      `CHK("status_ro", 16'h0000, rd)
   endtask

   task automatic t_bytes;
      step;
      bw = 1'b1;
      host.acc(1'b1, 1'b0, 7'h00, 16'h3C3C, rd);
      host.acc(1'b1, 1'b1, 7'h01, 16'hA5A5, rd);
      host.acc(1'b0, 1'b0, 7'h01, 16'h0000, rd); // low lane first
      `CHK("byte_lo", 16'h0022, rd)
      host.acc(1'b0, 1'b1, 7'h01, 16'h8000, rd);
      `CHK("byte_hi", 16'h00A5, rd)
      `CHK("lane_lo", 16'h113C, ctrl[0])
      `CHK("lane_hi", 16'hA522, ctrl[1])
      step;
      bw = 1'b0;
   endtask

   task automatic t_irqs;
      host.acc(1'b1, 1'b0, ADR_STAT_EN, 16'h0021, rd);
      host.acc(1'b1, 1'b0, ADR_LINK_EN, 16'h0001, rd);
      step;
      rx_clk_act = 1'b0;
      pulse_evt('{stat: 8'h01, hdlc: 1'b0, far_end_alarm_chan: 1'b0});
      pulse_evt('{stat: 8'h40, hdlc: 1'b1, far_end_alarm_chan: 1'b0});
      repeat (3) @(posedge clk_in);
      `CHK("masked", 2'b11, {sirq_oe, lirq_oe})
      pulse_evt('{stat: 8'h20, hdlc: 1'b0, far_end_alarm_chan: 1'b1});
      repeat (2) @(posedge clk_in);
      `CHK("irq_low", 2'b00, {sirq_oe, lirq_oe})
      host.acc(1'b0, 1'b0, ADR_STAT_STS, 16'h0000, rd);
      `CHK("stat_sts", 16'h0060, rd)
      host.acc(1'b0, 1'b0, ADR_LINK_STS, 16'h0000, rd);
      `CHK("link_sts", 16'h0003, rd)
      repeat (2) @(posedge clk_in);
      `CHK("irq_free", 2'b11, {sirq_oe, lirq_oe})
      rx_clk_act = 1'b1;
   endtask

   task automatic t_hold_reset;
      for (int i = 0; i < 3; i++) begin
         step;
         rx_hold = (i == 2);
         rx_cell = 1'b1;
         step;
         rx_cell = 1'b0;
      end
      host.acc(1'b0, 1'b0, ADR_RX_CNT, 16'h0000, rd);
      `CHK("rx_count", 16'h0002, rd)
      `CHK("rx_accept", 1'b0, rx_acc)
      host.acc(1'b1, 1'b0, ADR_CTRL_CLR, 16'hFFFF, rd);
      step;
      reset_in = 1'b1;
      // Hold released as the reset pin rises, so only the reset pin can idle the receiver
      rx_hold = 1'b0;
      repeat (2) @(posedge clk_in);
      #5;
      reset_in = 1'b0;
      `CHK("reset_idle", 1'b0, rx_acc)
      host.acc(1'b0, 1'b0, ADR_CTRL_CLR, 16'h0000, rd);
      `CHK("clr_bit", 16'hFDFF, rd)
      host.acc(1'b0, 1'b0, ADR_CTRL0, 16'h0000, rd);
      `CHK("kept_word", 16'h113C, rd)
   endtask

   task automatic t_second;
      int n;
      int k;
      step;
      line_st = 16'h5A3C;
      sec_sync = 1'b1;
      repeat (4) step;
      line_st = 16'h0F0F;
      sec_sync = 1'b0;
      host.acc(1'b0, 1'b0, ADR_LINE_SNAP, 16'h0000, rd);
      `CHK("snapshot", 16'h5A3C, rd)
      n = 0;
      for (k = 0; k < 30000 && sec_p !== 1'b1; k++) @(negedge clk_in);
      for (k = k + 1; k < 30000; k++) begin
         @(negedge clk_in);
         if (sec_p === 1'b1) break;
         if (fsync === 1'b1) n++;
      end
      if (k >= 30000) begin
         fails++;
         close_out;
      end
      `CHK("refs_per_sec", PER_SEC, n)
      host.acc(1'b0, 1'b0, ADR_STAT_STS, 16'h0000, rd);
      `CHK("sec_status", 16'h0200, rd)
   endtask

   initial begin
      fails = 0;
      checks_done = 0;
      rst_n_in = 1'b0;
      reset_in = 1'b0;
      bw = 1'b0;
      sec_sync = 1'b0;
      rx_hold = 1'b0;
      rx_clk_act = 1'b1;
      rx_cell = 1'b0;
      evt = '0;
      line_st = 16'h0000;
      repeat (10) @(posedge clk_in);
      #5;
      rst_n_in = 1'b1;
      step;
      t_reset_vals;
      t_words;
      t_bytes;
      t_irqs;
      t_hold_reset;
      t_second;
      close_out;
   end
endmodule
`default_nettype wire
